// file: core/smbt_top.sv
`timescale 1ns/1ps
module smbt_top import smbt_pkg::*; #(
   parameter int STRETCH_CYCLES = STRETCH_CYC,
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int RECOVER_CYCLES = RECOVER_CYC,
   parameter int WR_CYCLES      = WR_CYC
) (
   input  wire logic       sys_clk_i,
   input  wire logic       arst_n_i,
   input  wire logic       link_clk_i,
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic       addr_strap_low_i,
   input  wire logic       addr_strap_mid_i,
   input  wire logic       addr_strap_high_reserved_i,
   input  wire logic       shutdown_evt_i,
   input  wire logic       warning_evt_i,
   output logic            fault_alert_out_n_o,
   output logic            ctrl_wr_stb_o,
   output logic            ctrl_rd_stb_o,
   output logic            ctrl_end_stb_o,
   output logic [7:0]      ctrl_idx_o,
   output logic [7:0]      ctrl_wdata_o,
   input  wire logic [7:0] ctrl_rdata_i
);
   localparam int STW = $clog2(STRETCH_CYCLES + 1);
   localparam int TOW = $clog2(TIMEOUT_CYCLES + 1);
   localparam int RCW = $clog2(RECOVER_CYCLES + 1);

   smbt_mem_if mem_bus ();

   // ===========================================================
   // link domain: reset release, synchronisers
   logic [1:0]  lrst;
   logic        link_rst_n;
   logic [6:0]  lsync;
   logic        s_scl, s_sda, abort_l, ack_l, busy_l;
   logic [1:0]  strap;
   smbt_state_t st;
   logic [2:0]  bit_cnt;
   logic [7:0]  shreg, idx, loc, wdata, rq_addr, rq_data, rsp;
   logic        got, sel_ee, rd, live, pend_wr, m_ack;
   logic        p_scl, p_sda, req_tgl, ack_tgl, abort_q, pin_lvl;
   smbt_req_t   rq_kind;

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lrst <= 2'b00;
      end else begin
         lrst <= {lrst[0], 1'b1};
      end
   end
   assign link_rst_n = lrst[1];

   smbt_sync #(.W(7), .RST(LSYNC_RST)) u_lsync (
      .clk_i   (link_clk_i),
      .rst_n_i (link_rst_n),
      .d_i     ({scl_i, sda_i, addr_strap_mid_i, addr_strap_low_i,
                 abort_q, ack_tgl, mem_bus.busy}),
      .q_o     (lsync)
   );
   // open strap reads high, high strap held at zero
   assign {s_scl, s_sda, strap, abort_l, ack_l, busy_l} = lsync;

   // ===========================================================
   // link domain: bus conditions and address match
   logic scl_rise, scl_fall, start, stop, hs_idle;
   logic match_ee, match_ct, hit;

   assign scl_rise = s_scl && !p_scl;
   assign scl_fall = !s_scl && p_scl;
   assign start    = p_sda && !s_sda && s_scl && p_scl;
   assign stop     = !p_sda && s_sda && s_scl && p_scl;
   assign hs_idle  = (req_tgl == ack_l);
   assign match_ee = (shreg[7:1] == smbt_tgt(EE_BASE7, strap));
   assign match_ct = (shreg[7:1] == smbt_tgt(CTRL_BASE7, strap));
   assign hit      = (match_ee && !busy_l) || match_ct;

   // ===========================================================
   // link domain: transfer engine
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         st      <= ST_IDLE;
         bit_cnt <= 3'h0;
         shreg   <= 8'h00;
         got     <= 1'b0;
         sel_ee  <= 1'b0;
         rd      <= 1'b0;
         live    <= 1'b0;
         idx     <= 8'h00;
         loc     <= 8'h00;
         wdata   <= 8'h00;
         pend_wr <= 1'b0;
         m_ack   <= 1'b0;
         p_scl   <= 1'b1;
         p_sda   <= 1'b1;
         req_tgl <= 1'b0;
         rq_kind <= RQ_EE_WR;
         rq_addr <= 8'h00;
         rq_data <= 8'h00;
      end else begin
         p_scl <= s_scl;
         p_sda <= s_sda;
         if (abort_l) begin
            st      <= ST_IDLE;
            pend_wr <= 1'b0;
            live    <= 1'b0;
         end else if (start) begin
            st      <= ST_ADDR;
            bit_cnt <= 3'h0;
            got     <= 1'b0;
            idx     <= 8'h00;
         end else if (stop) begin
            st <= ST_IDLE;
            if (hs_idle && live && sel_ee && pend_wr) begin
               rq_kind <= RQ_EE_WR;
               rq_addr <= loc;
               rq_data <= wdata;
               req_tgl <= !req_tgl;
            end else if (hs_idle && live && !sel_ee) begin
               rq_kind <= RQ_CT_END;
               rq_addr <= idx;
               req_tgl <= !req_tgl;
            end
            pend_wr <= 1'b0;
            live    <= 1'b0;
         end else begin
            unique case (st)
               ST_IDLE: begin
               end
               ST_ADDR, ST_RX: begin
                  if (scl_rise) begin
                     shreg   <= {shreg[6:0], s_sda};
                     bit_cnt <= bit_cnt + 3'h1;
                     got     <= (bit_cnt == 3'h7);
                  end else if (scl_fall && got) begin
                     got <= 1'b0;
                     if (st == ST_ADDR) begin
                        if (hit) begin
                           sel_ee <= match_ee;
                           rd     <= shreg[0];
                           live   <= 1'b1;
                           st     <= ST_AACK;
                        end else begin
                           st <= ST_IDLE;
                        end
                     end else if (sel_ee) begin
                        if (idx == 8'h00) begin
                           loc <= shreg;
                        end else begin
                           wdata   <= shreg;
                           pend_wr <= 1'b1;
                        end
                        if (idx != CTRL_MAX_IDX) begin
                           idx <= idx + 8'h01;
                        end
                        st <= ST_RACK;
                     end else if (idx == CTRL_MAX_IDX) begin
                        st <= ST_IDLE;
                     end else begin
                        rq_kind <= RQ_CT_WR;
                        rq_addr <= idx;
                        rq_data <= shreg;
                        req_tgl <= !req_tgl;
                        idx     <= idx + 8'h01;
                        st      <= ST_HOLD;
                     end
                  end
               end
               ST_AACK: begin
                  if (scl_fall) begin
                     bit_cnt <= 3'h0;
                     if (rd) begin
                        rq_kind <= sel_ee ? RQ_EE_RD : RQ_CT_RD;
                        rq_addr <= sel_ee ? loc : idx;
                        req_tgl <= !req_tgl;
                        st      <= ST_FETCH;
                     end else begin
                        st <= ST_RX;
                     end
                  end
               end
               ST_HOLD: begin
                  if (hs_idle) begin
                     st <= ST_RACK;
                  end
               end
               ST_RACK: begin
                  if (scl_fall) begin
                     bit_cnt <= 3'h0;
                     st      <= ST_RX;
                  end
               end
               ST_FETCH: begin
                  if (hs_idle) begin
                     shreg   <= rsp;
                     bit_cnt <= 3'h0;
                     st      <= ST_TX;
                     if (sel_ee) begin
                        loc <= loc + 8'h01;
                     end else if (idx != CTRL_MAX_IDX) begin
                        idx <= idx + 8'h01;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt == 3'h7) begin
                        st <= ST_TACK;
                     end else begin
                        shreg   <= {shreg[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 3'h1;
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise) begin
                     m_ack <= !s_sda;
                  end else if (scl_fall) begin
                     if (m_ack && (sel_ee || idx != CTRL_MAX_IDX)) begin
                        rq_kind <= sel_ee ? RQ_EE_RD : RQ_CT_RD;
                        rq_addr <= sel_ee ? loc : idx;
                        req_tgl <= !req_tgl;
                        st      <= ST_FETCH;
                     end else begin
                        st <= ST_IDLE;
                     end
                  end
               end
               default: st <= ST_IDLE;
            endcase
         end
      end
   end

   // ===========================================================
   // link domain: pin drive, low only and switched on only while clock low
   always_ff @(posedge link_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sda_oe_o <= 1'b0;
         scl_oe_o <= 1'b0;
         pin_lvl  <= 1'b0;
      end else begin
         pin_lvl  <= 1'b0;
         sda_oe_o <= !abort_l && (st == ST_AACK || st == ST_RACK ||
                     st == ST_HOLD || (st == ST_TX && !shreg[7]));
         scl_oe_o <= !abort_l && (st == ST_FETCH || st == ST_HOLD);
      end
   end
   assign scl_o = pin_lvl;
   assign sda_o = pin_lvl;

   // ===========================================================
   // system domain: alert, watchdogs, request service
   logic [2:0]     ssync;
   logic           scl_s, stretch_s, req_s, p_req, svc;
   logic [STW-1:0] st_cnt;
   logic [TOW-1:0] low_cnt;

   smbt_sync #(.W(3), .RST(SSYNC_RST)) u_ssync (
      .clk_i   (sys_clk_i),
      .rst_n_i (arst_n_i),
      .d_i     ({scl_i, scl_oe_o, req_tgl}),
      .q_o     (ssync)
   );
   assign {scl_s, stretch_s, req_s} = ssync;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         fault_alert_out_n_o <= ALERT_RST;
      end else begin
         fault_alert_out_n_o <= !(shutdown_evt_i || warning_evt_i);
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_cnt <= '0;
         st_cnt  <= '0;
         abort_q <= 1'b0;
      end else begin
         if (scl_s) begin
            low_cnt <= '0;
         end else if (low_cnt != TOW'(TIMEOUT_CYCLES)) begin
            low_cnt <= low_cnt + TOW'(1);
         end
         if (!stretch_s) begin
            st_cnt <= '0;
         end else if (st_cnt != STW'(STRETCH_CYCLES)) begin
            st_cnt <= st_cnt + STW'(1);
         end
         abort_q <= (low_cnt == TOW'(TIMEOUT_CYCLES)) ||
                    (st_cnt == STW'(STRETCH_CYCLES));
      end
   end

   // payload fields are stable link flops once the toggle is seen here
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         p_req          <= 1'b0;
         svc            <= 1'b0;
         ack_tgl        <= 1'b0;
         rsp            <= 8'h00;
         mem_bus.wr_stb <= 1'b0;
         ctrl_wr_stb_o  <= 1'b0;
         ctrl_rd_stb_o  <= 1'b0;
         ctrl_end_stb_o <= 1'b0;
         ctrl_idx_o     <= 8'h00;
         ctrl_wdata_o   <= 8'h00;
      end else begin
         p_req          <= req_s;
         svc            <= (req_s != p_req);
         mem_bus.wr_stb <= (req_s != p_req) && rq_kind == RQ_EE_WR;
         ctrl_wr_stb_o  <= (req_s != p_req) && rq_kind == RQ_CT_WR;
         ctrl_rd_stb_o  <= (req_s != p_req) && rq_kind == RQ_CT_RD;
         ctrl_end_stb_o <= (req_s != p_req) && rq_kind == RQ_CT_END;
         if (req_s != p_req) begin
            ctrl_idx_o   <= rq_addr;
            ctrl_wdata_o <= rq_data;
         end
         if (svc) begin
            rsp     <= (rq_kind == RQ_CT_RD) ? ctrl_rdata_i : mem_bus.rdata;
            ack_tgl <= !ack_tgl;
         end
      end
   end
   assign mem_bus.addr  = rq_addr;
   assign mem_bus.wdata = rq_data;

   smbt_eeprom #(.DEPTH(EE_DEPTH), .WR_CYCLES(WR_CYCLES)) u_eeprom (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .m         (mem_bus.mem)
   );

   // ===========================================================
   // checks
   logic [RCW-1:0] rec_cnt;
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rec_cnt <= '0;
      end else if (abort_q && stretch_s) begin
         rec_cnt <= rec_cnt + RCW'(1);
      end else begin
         rec_cnt <= '0;
      end
   end

   property p_no_start_gen;
      @(posedge link_clk_i) disable iff (!link_rst_n)
      $rose(sda_oe_o) |-> !s_scl;
   endproperty
   a_no_start_gen: assert property (p_no_start_gen)
      else $error("data driven low while clock high");

   property p_alert;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (shutdown_evt_i || warning_evt_i) |=> !fault_alert_out_n_o;
   endproperty
   a_alert: assert property (p_alert)
      else $error("alert not asserted on event");

   property p_stretch_cap;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (stretch_s && st_cnt == STW'(STRETCH_CYCLES)) |=> abort_q;
   endproperty
   a_stretch_cap: assert property (p_stretch_cap)
      else $error("stretch limit not enforced");

   property p_timeout;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (!scl_s && low_cnt == TOW'(TIMEOUT_CYCLES)) |=> abort_q;
   endproperty
   a_timeout: assert property (p_timeout)
      else $error("clock low timeout missed");

   property p_recover;
      @(posedge link_clk_i) disable iff (!link_rst_n)
      abort_l |=> (st == ST_IDLE) && !scl_oe_o && !sda_oe_o;
   endproperty
   a_recover: assert property (p_recover)
      else $error("link not idle after abort");

   property p_recover_bound;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      rec_cnt < RCW'(RECOVER_CYCLES);
   endproperty
   a_recover_bound: assert property (p_recover_bound)
      else $error("recovery took too long");

   property p_addr_ack;
      @(posedge link_clk_i) disable iff (!link_rst_n)
      (st == ST_ADDR && scl_fall && got && !abort_l && !start && !stop)
      |=> (st == ST_AACK) == $past(hit);
   endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("address acknowledge wrong");

   property p_start_resync;
      @(posedge link_clk_i) disable iff (!link_rst_n)
      (start && !abort_l) |=> (st == ST_ADDR) && (bit_cnt == 3'h0);
   endproperty
   a_start_resync: assert property (p_start_resync)
      else $error("start did not resynchronise");

   property p_ee_write;
      @(posedge link_clk_i) disable iff (!link_rst_n)
      (stop && !abort_l && hs_idle && live && sel_ee && pend_wr)
      |=> (req_tgl != $past(req_tgl)) && rq_kind == RQ_EE_WR;
   endproperty
   a_ee_write: assert property (p_ee_write)
      else $error("storage write not issued at stop");

   c_ee_write: cover property (@(posedge sys_clk_i) mem_bus.wr_stb);
   c_ct_read:  cover property (@(posedge sys_clk_i) ctrl_rd_stb_o);
   c_timeout:  cover property (@(posedge sys_clk_i) abort_q && !scl_s);
endmodule

// file: core/smbt_pkg.sv
// Behaviour
// - device is target only; never drives START nor originates clocking
// - alert output low whenever any shutdown or warning event is present
// - bus runs at standard-mode rates up to 100 kbps, all accepted
// - device releases a stretched clock line within 1 ms
// - clock low beyond 25 ms abandons transfer, idle within 10 ms
// - strap reads low when grounded, high when open via pull-up
// - controller at 0xB0 plus twice strap, storage at 0xA0 plus twice strap
// - highest strap reserved, treated as zero
// - first byte bit zero is direction, upper seven bits the address
// - both targets share the lines, each answers only its own address
// - storage target offers 256 user bytes untouched by the supply
// - storage write: address+write, location, data, stop; each byte acked
// - storage read: location write, repeated start, address+read, byte out
// - controller write may end after command, one or two data bytes
// - controller block transfers accepted up to 255 bytes total
package smbt_pkg;

   localparam int SYS_HZ      = 40_000_000;
   localparam int STRETCH_MS  = 1;
   localparam int TIMEOUT_MS  = 25;
   localparam int RECOVER_MS  = 10;
   localparam int WR_CYCLE_MS = 5;
   localparam int STRETCH_CYC = SYS_HZ / 1000 * STRETCH_MS;
   localparam int TIMEOUT_CYC = SYS_HZ / 1000 * TIMEOUT_MS + 1;
   localparam int RECOVER_CYC = SYS_HZ / 1000 * RECOVER_MS;
   localparam int WR_CYC      = SYS_HZ / 1000 * WR_CYCLE_MS;

   localparam logic [6:0] CTRL_BASE7   = 7'h58;
   localparam logic [6:0] EE_BASE7     = 7'h50;
   localparam int         EE_DEPTH     = 256;
   localparam logic [7:0] CTRL_MAX_IDX = 8'hFF;
   localparam logic       ALERT_RST    = 1'b1;
   localparam logic [6:0] LSYNC_RST    = 7'h78;
   localparam logic [2:0] SSYNC_RST    = 3'h4;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_ADDR  = 4'b0001,
      ST_AACK  = 4'b0010,
      ST_RX    = 4'b0011,
      ST_HOLD  = 4'b0100,
      ST_RACK  = 4'b0101,
      ST_FETCH = 4'b0110,
      ST_TX    = 4'b0111,
      ST_TACK  = 4'b1000
   } smbt_state_t;

   typedef enum logic [2:0] {
      RQ_EE_WR  = 3'b000,
      RQ_EE_RD  = 3'b001,
      RQ_CT_WR  = 3'b010,
      RQ_CT_RD  = 3'b011,
      RQ_CT_END = 3'b100
   } smbt_req_t;

   function automatic logic [6:0] smbt_tgt(input logic [6:0] base,
                                            input logic [1:0] strap);
      return base + {5'h00, strap};
   endfunction

endpackage

// file: core/smbt_mem_if.sv
`timescale 1ns/1ps
interface smbt_mem_if;
   logic       wr_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       busy;
   modport user (output wr_stb, addr, wdata, input rdata, busy);
   modport mem  (input wr_stb, addr, wdata, output rdata, busy);
endinterface

// file: core/smbt_sync.sv
`timescale 1ns/1ps
module smbt_sync #(
   parameter int             W   = 1,
   parameter logic [W-1:0]   RST = '0
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= RST;
         q_o  <= RST;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule

// file: core/smbt_eeprom.sv
`timescale 1ns/1ps
module smbt_eeprom import smbt_pkg::*; #(
   parameter int DEPTH     = EE_DEPTH,
   parameter int WR_CYCLES = WR_CYC
) (
   input  wire logic sys_clk_i,
   input  wire logic arst_n_i,
   smbt_mem_if.mem   m
);
   localparam int CW = $clog2(WR_CYCLES + 1);

   logic [7:0]    store [DEPTH];
   logic [CW-1:0] wr_cnt;

   // ===========================================================
   // storage array, write cycle timer
   always_ff @(posedge sys_clk_i) begin
      if (m.wr_stb && !m.busy) begin
         store[m.addr] <= m.wdata;
      end
   end

   // busy kept in a flop: it crosses into the link domain glitch free
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_cnt <= '0;
         m.busy <= 1'b0;
      end else if (m.wr_stb && !m.busy) begin
         wr_cnt <= CW'(WR_CYCLES);
         m.busy <= 1'b1;
      end else if (wr_cnt != '0) begin
         wr_cnt <= wr_cnt - CW'(1);
         m.busy <= (wr_cnt != CW'(1));
      end
   end

   assign m.rdata = store[m.addr];

   // ===========================================================
   // checks
   property p_busy_after_write;
      @(posedge sys_clk_i) disable iff (!arst_n_i)
      (m.wr_stb && !m.busy) |=> m.busy [*8];
   endproperty
   a_busy_after_write: assert property (p_busy_after_write)
      else $error("write cycle not busy after write");
endmodule

// file: test/smbt_host.sv
`timescale 1ns/1ps
module smbt_host (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_oe_o,
   output logic      sda_oe_o,
   output logic      stuck_o
);
   // ==========
   // bus master
   localparam time HALF = 5000;
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
      stuck_o  = 1'b0;
   end
   // release clock, bounded wait on stretch
   task automatic rise(output logic r);
      int n;
      scl_oe_o = 1'b0;
      for (n = 0; n < 4000 && scl_i !== 1'b1; n++)
         #10;
      if (n == 4000)
         stuck_o = 1'b1;
      #(HALF / 2);
      r = sda_i;
   endtask
   task automatic bit_io(input logic b, output logic r);
      #(HALF / 2);
      sda_oe_o = ~b;
      #(HALF / 2);
      rise(r);
      #(HALF / 2);
      scl_oe_o = 1'b1;
   endtask
   task automatic start();
      logic r;
      #(HALF / 2);
      sda_oe_o = 1'b0;
      #(HALF / 2);
      rise(r);
      sda_oe_o = 1'b1;
      #(HALF / 2);
      scl_oe_o = 1'b1;
   endtask
   task automatic stop();
      logic r;
      #(HALF / 2);
      sda_oe_o = 1'b1;
      #(HALF / 2);
      rise(r);
      sda_oe_o = 1'b0;
      #HALF;
   endtask
   // single bytes only, msb first
   task automatic byte_io(input logic [7:0] d, input logic m,
                          output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(m, a);
   endtask
endmodule

// file: test/smbt_top_bench.sv
`timescale 1ns/1ps
module smbt_top_bench;
   localparam int WRC = 6000;
   localparam int TOC = 400;
   localparam int RCC = 100;
   logic        sys_clk = 1'b0;
   logic        link_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        s_low, s_mid, s_high, shut, warn, stuck;
   logic        h_scl_oe, h_sda_oe, d_scl_oe, d_sda_oe, alert_n;
   logic        wr_stb, end_stb, rd_stb, d_scl_o, d_sda_o;
   logic [7:0]  idx, wdata, rdata, loc, dat;
   logic [15:0] lfsr = 16'h4AEE;
   logic [16:0] exp_q[$];
   int          err_count = 0;
   int          total_checks = 0;
   wire         scl = ~h_scl_oe & (d_scl_oe ? d_scl_o : 1'b1);
   wire         sda = ~h_sda_oe & (d_sda_oe ? d_sda_o : 1'b1);
   always #12.5 sys_clk = ~sys_clk;
   always #7.5 link_clk = ~link_clk;
   smbt_host h (.scl_i(scl), .sda_i(sda), .scl_oe_o(h_scl_oe),
      .sda_oe_o(h_sda_oe), .stuck_o(stuck));
   smbt_top #(.STRETCH_CYCLES(200), .TIMEOUT_CYCLES(TOC),
      .RECOVER_CYCLES(RCC), .WR_CYCLES(WRC)) dut (
      .sys_clk_i(sys_clk), .arst_n_i(arst_n), .link_clk_i(link_clk),
      .scl_i(scl), .scl_o(d_scl_o), .scl_oe_o(d_scl_oe), .sda_i(sda),
      .sda_o(d_sda_o), .sda_oe_o(d_sda_oe), .addr_strap_low_i(s_low),
      .addr_strap_mid_i(s_mid), .addr_strap_high_reserved_i(s_high),
      .shutdown_evt_i(shut), .warning_evt_i(warn),
      .fault_alert_out_n_o(alert_n), .ctrl_wr_stb_o(wr_stb),
      .ctrl_rd_stb_o(rd_stb), .ctrl_end_stb_o(end_stb), .ctrl_idx_o(idx),
      .ctrl_wdata_o(wdata), .ctrl_rdata_i(rdata));
   // ==========
   // helpers
   function automatic logic [15:0] nx(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic chk(input string nm, input logic [16:0] e,
                      input logic [16:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic [7:0] d, input logic ea);
      logic [7:0] q;
      logic       a;
      h.byte_io(d, 1'b1, q, a);
      chk("ack", {16'h0000, ea}, {16'h0000, a});
   endtask
   task automatic rb(input logic [7:0] e);
      logic [7:0] q;
      logic       a;
      h.byte_io(8'hFF, 1'b1, q, a);
      chk("rdata", {9'h000, e}, {9'h000, q});
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ==========
   // watchers
   always @(negedge sys_clk)
      if ((wr_stb | end_stb | rd_stb) === 1'b1) begin
         if (exp_q.size() == 0)
            chk("ctrl_extra", 17'h0_0000, 17'h1_FFFF);
         else
            chk("ctrl_stb", exp_q.pop_front(),
                {end_stb | rd_stb, idx,
                 end_stb ? 8'h00 : (rd_stb ? 8'hFF : wdata)});
      end
   initial begin
      for (int n = 0; n < 99000 && stuck !== 1'b1; n++)
         @(posedge sys_clk);
      chk("watchdog", 17'h0_0000, 17'h0_0001);
      end_sim();
   end
   // ==========
   // main sequence
   initial begin
      {s_high, s_mid, s_low, shut, warn} = 5'h00;
      rdata = 8'h00;
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (20) @(negedge sys_clk);
      chk("idle_oe", 17'h0_0000,
          {13'h0000, d_scl_o, d_sda_o, d_scl_oe, d_sda_oe});
      for (int i = 0; i < 4; i++) begin
         {shut, warn} = 2'(i);
         @(negedge sys_clk);
         chk("alert", {16'h0000, i == 0}, {16'h0000, alert_n});
      end
      for (int s = 0; s < 4; s++) begin
         @(negedge sys_clk);
         lfsr = nx(lfsr);
         {s_high, s_mid, s_low} = {lfsr[0], 2'(s)};
         repeat (8) @(negedge sys_clk);
         exp_q.push_back({1'b1, 16'h0000});
         h.start();
         wb(8'hB0 + 8'(2 * s), 1'b0);
         h.stop();
         h.start();
         wb(8'hB8 + 8'(2 * s), 1'b1);
         h.stop();
      end
      lfsr = nx(lfsr);
      exp_q.push_back({9'h000, lfsr[7:0]});
      exp_q.push_back({9'h001, lfsr[15:8]});
      exp_q.push_back({9'h102, 8'h00});
      h.start();
      wb(8'hB6, 1'b0);
      wb(lfsr[7:0], 1'b0);
      wb(lfsr[15:8], 1'b0);
      h.stop();
      @(negedge sys_clk);
      rdata = {1'b0, lfsr[6:0]};
      exp_q.push_back({9'h100, 8'hFF});
      h.start();
      wb(8'hB7, 1'b0);
      repeat (50) @(negedge sys_clk);
      chk("rd_bit7", 17'h0_0001, {16'h0000, d_sda_oe});
      repeat (TOC + RCC) @(negedge sys_clk);
      chk("abort_oe", 17'h0_0000, {15'h0000, d_scl_oe, d_sda_oe});
      h.stop();
      lfsr = nx(lfsr);
      {loc, dat} = lfsr;
      h.start();
      wb(8'hA6, 1'b0);
      wb(loc, 1'b0);
      wb(dat, 1'b0);
      h.stop();
      h.start();
      wb(8'hA6, 1'b1);
      h.stop();
      repeat (WRC / 2) @(posedge sys_clk);
      h.start();
      wb(8'hA6, 1'b0);
      wb(loc, 1'b0);
      h.start();
      wb(8'hA7, 1'b0);
      rb(dat);
      h.stop();
      end_sim();
   end
endmodule
